// ==== src/ddc_pkg.sv ====
package ddc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_SLICE     = 8'h4f;
	localparam logic [7:0] IDX_ECC_CFG   = 8'h50;
	localparam logic [7:0] IDX_ERR_STAT  = 8'h51;
	localparam logic [7:0] IDX_RSVD      = 8'h52;
	localparam logic [7:0] IDX_PWB       = 8'h53;
	localparam logic [7:0] IDX_HOLE      = 8'h54;
	localparam logic [7:0] IDX_SMM       = 8'h55;
	localparam logic [7:0] IDX_SHAD_LO   = 8'h56;
	localparam logic [7:0] IDX_SHAD_HI   = 8'h57;
	localparam logic [7:0] REG_RESET     = 8'h00;
	localparam int         ADDR_W        = 12;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;
	// Slice register fields
	localparam int         SLICE_AGP_LSB = 4;
	localparam int         SLICE_PCI_LSB = 0;
	// Error check configuration fields
	localparam int         ECC_SERR_LVL  = 6;
	localparam int         ECC_MB_EN     = 5;
	localparam int         ECC_SB_EN     = 4;
	localparam int         ECC_MODE      = 0;
	localparam logic [7:0] ECC_CFG_MASK  = 8'h71;
	// Error status fields
	localparam int         STAT_MB_ROW   = 5;
	localparam int         STAT_MB_FLAG  = 4;
	localparam int         STAT_SB_ROW   = 1;
	localparam int         STAT_SB_FLAG  = 0;
	// Posted write control fields
	localparam int         PWB_IDLE_LSB  = 6;
	localparam int         PWB_NO_OVL_WR = 5;
	localparam int         PWB_NO_OVL_RD = 4;
	localparam int         PWB_TMR_LSB   = 1;
	localparam int         PWB_IMMED     = 0;
	// Memory hole fields
	localparam int         HOLE_14M      = 5;
	localparam int         HOLE_15M      = 4;
	localparam int         HOLE_AB       = 3;
	localparam int         HOLE_80K      = 2;
	localparam logic [7:0] HOLE_MASK     = 8'h3c;
	// SMRAM mapping fields
	localparam int         SMM_SPLIT     = 4;
	localparam int         SMM_REG_LSB   = 2;
	localparam int         SMM_ANY       = 1;
	localparam int         SMM_MAP       = 0;
	localparam logic [7:0] SMM_MASK      = 8'h1f;
	localparam logic [1:0] SMM_D_TO_B    = 2'h0;
	localparam logic [1:0] SMM_AB_SELF   = 2'h1;
	localparam logic [1:0] SMM_3_TO_B    = 2'h2;
	// Address windows
	localparam logic [15:0] SEG_3        = 16'h0003;
	localparam logic [15:0] SEG_A        = 16'h000a;
	localparam logic [15:0] SEG_B        = 16'h000b;
	localparam logic [15:0] SEG_D        = 16'h000d;
	localparam logic [14:0] WIN_80K      = 15'h0004;
	localparam logic [13:0] WIN_SHADOW   = 14'h0003;
	localparam logic [11:0] WIN_14M      = 12'h00e;
	localparam logic [11:0] WIN_15M      = 12'h00f;
	localparam logic [31:0] TOP_15M      = 32'h00f0_0000;
	localparam logic [31:0] TOP_16M      = 32'h0100_0000;
	// Timing counts in clocks
	localparam int         IDLE_STEP     = 2;
	localparam logic [5:0] FLUSH_4       = 6'h04;
	localparam logic [5:0] FLUSH_8       = 6'h08;
	localparam logic [5:0] FLUSH_12      = 6'h0c;
	localparam logic [5:0] FLUSH_16      = 6'h10;
	localparam logic [5:0] FLUSH_32      = 6'h20;
	// Arbiter states
	typedef enum logic [1:0] {ARB_IDLE, ARB_AGP, ARB_PCI} ddc_arb_t;
endpackage

// ==== src/ddc_regs.sv ====
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module ddc_regs
	import ddc_pkg::*;
(
	// Clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// AXI4-Lite write channels
	input  wire logic [ddc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [ddc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// DRAM requesters
	input  wire logic                   agp_req,
	input  wire logic                   pci_req,
	input  wire logic                   cmd_done,
	output logic                        agp_gnt,
	output logic                        pci_gnt,
	// DRAM error events
	input  wire logic                   err_parity,
	input  wire logic                   err_multi,
	input  wire logic                   err_single,
	input  wire logic [2:0]             err_row,
	output logic                        ecc_mode,
	output logic                        mb_check_en,
	output logic                        sb_check_en,
	output logic                        system_error_n,
	// Host clock gating
	input  wire logic                   gate_clk_en,
	input  wire logic                   cpu_idle,
	output logic                        host_clk_run,
	// Posted write buffer
	input  wire logic                   pwb_pending,
	input  wire logic                   pwb_write,
	output logic                        pwb_flush,
	output logic                        ovl_pci_wr_ok,
	output logic                        ovl_pci_rd_ok,
	// Address decode
	input  wire logic [31:0]            mem_addr,
	input  wire logic                   mem_read,
	input  wire logic [31:0]            dram_top,
	input  wire logic                   smm_active_n,
	input  wire logic                   code_data_indicator_n,
	output logic                        dram_local,
	output logic [31:0]                 dram_addr
);
	import ddc_pkg::*;

	logic [7:0]  slice;
	logic [7:0]  ecc_cfg;
	logic [7:0]  err_stat;
	logic [7:0]  pwb_ctl;
	logic [7:0]  hole;
	logic [7:0]  smm_cfg;
	logic [15:0] shadow;
	logic        wr_take;
	logic        rd_take;
	logic [7:0]  wr_idx;
	logic        wr_hit;
	logic        wr_byte;
	logic [7:0]  rd_idx;
	logic [7:0]  rd_val;
	logic        rd_hit;
	ddc_arb_t    arb;
	logic [3:0]  cmd_cnt;
	logic        last_agp;
	logic [3:0]  gnt_slice;
	logic        slice_end;
	logic        mb_evt;
	logic        sb_evt;
	logic        mb_clr;
	logic        sb_clr;
	logic        next_mb;
	logic        next_sb;
	logic [3:0]  idle_cnt;
	logic [3:0]  idle_lim;
	logic [5:0]  flush_cnt;
	logic [5:0]  flush_lim;
	logic [1:0]  smm_act_s;
	logic [1:0]  cd_s;
	logic        smm_ok;
	logic [15:0] seg;
	logic        next_local;
	logic [31:0] next_addr;

	// Bus handshake: one write and one read under way at a time
	assign wr_take       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign rd_take       = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_awready = wr_take;
	assign s_axi_wready  = wr_take;
	assign s_axi_arready = rd_take;
	assign wr_idx  = s_axi_awaddr[9:2];
	assign rd_idx  = s_axi_araddr[9:2];
	// Unmapped words must not alias onto a register through the index bits
	assign wr_byte = wr_take && wr_hit && s_axi_wstrb[0];

	// Unmapped words answer with SLVERR
	always_comb begin
		wr_hit = (s_axi_awaddr[ADDR_W-1:10] == '0)
			&& (wr_idx >= IDX_SLICE) && (wr_idx <= IDX_SHAD_HI);
		rd_hit = (s_axi_araddr[ADDR_W-1:10] == '0)
			&& (rd_idx >= IDX_SLICE) && (rd_idx <= IDX_SHAD_HI);
	end

	// Write response channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_take) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read mux; reserved bits read as zero
	always_comb begin
		case (rd_idx)
			IDX_SLICE:    rd_val = slice;
			IDX_ECC_CFG:  rd_val = ecc_cfg;
			IDX_ERR_STAT: rd_val = err_stat;
			IDX_PWB:      rd_val = pwb_ctl;
			IDX_HOLE:     rd_val = hole;
			IDX_SMM:      rd_val = smm_cfg;
			IDX_SHAD_LO:  rd_val = shadow[7:0];
			IDX_SHAD_HI:  rd_val = shadow[15:8];
			default:      rd_val = REG_RESET;
		endcase
	end

	// Read data channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h0, rd_hit ? rd_val : REG_RESET};
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Plain read/write configuration bytes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slice   <= REG_RESET;
			ecc_cfg <= REG_RESET;
			pwb_ctl <= REG_RESET;
			hole    <= REG_RESET;
			smm_cfg <= REG_RESET;
			shadow  <= {REG_RESET, REG_RESET};
		end else if (wr_byte) begin
			case (wr_idx)
				IDX_SLICE:   slice   <= s_axi_wdata[7:0];
				IDX_ECC_CFG: ecc_cfg <= s_axi_wdata[7:0] & ECC_CFG_MASK;
				IDX_PWB:     pwb_ctl <= s_axi_wdata[7:0];
				IDX_HOLE:    hole    <= s_axi_wdata[7:0] & HOLE_MASK;
				IDX_SMM:     smm_cfg <= s_axi_wdata[7:0] & SMM_MASK;
				IDX_SHAD_LO: shadow[7:0]  <= s_axi_wdata[7:0];
				IDX_SHAD_HI: shadow[15:8] <= s_axi_wdata[7:0];
				default:     ;
			endcase
		end
	end

	// Slice of the granted master, n meaning n+1 commands
	always_comb begin
		gnt_slice = (arb == ARB_AGP) ? slice[SLICE_AGP_LSB+:4]
			: slice[SLICE_PCI_LSB+:4];
		slice_end = cmd_done && (cmd_cnt == gnt_slice);
	end

	// DRAM grant: round robin between AGP and PCI
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arb      <= ARB_IDLE;
			cmd_cnt  <= 4'h0;
			last_agp <= 1'b0;
		end else begin
			case (arb)
				ARB_IDLE: begin
					cmd_cnt <= 4'h0;
					if (agp_req && (!pci_req || !last_agp)) begin
						arb      <= ARB_AGP;
						last_agp <= 1'b1;
					end else if (pci_req) begin
						arb      <= ARB_PCI;
						last_agp <= 1'b0;
					end
				end
				ARB_AGP, ARB_PCI: begin
					if (slice_end || (arb == ARB_AGP ? !agp_req : !pci_req)) begin
						arb     <= ARB_IDLE;
						cmd_cnt <= 4'h0;
					end else if (cmd_done) begin
						cmd_cnt <= cmd_cnt + 4'h1;
					end
				end
				default: arb <= ARB_IDLE;
			endcase
		end
	end
	assign agp_gnt = (arb == ARB_AGP);
	assign pci_gnt = (arb == ARB_PCI);

	// Checking is off whenever its reporting enable is off
	assign ecc_mode    = ecc_cfg[ECC_MODE];
	assign mb_check_en = ecc_cfg[ECC_MB_EN];
	assign sb_check_en = ecc_cfg[ECC_SB_EN] && ecc_cfg[ECC_MODE];
	assign mb_evt = mb_check_en
		&& (ecc_mode ? err_multi : err_parity);
	assign sb_evt = sb_check_en && err_single;
	assign mb_clr = wr_byte && (wr_idx == IDX_ERR_STAT)
		&& s_axi_wdata[STAT_MB_FLAG];
	assign sb_clr = wr_byte && (wr_idx == IDX_ERR_STAT)
		&& s_axi_wdata[STAT_SB_FLAG];
	// A new error wins over a clear in the same cycle
	assign next_mb = mb_evt || (err_stat[STAT_MB_FLAG] && !mb_clr);
	assign next_sb = sb_evt || (err_stat[STAT_SB_FLAG] && !sb_clr);

	// Error status: rows only load while their flag is clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_stat <= REG_RESET;
		end else begin
			err_stat[STAT_MB_FLAG] <= next_mb;
			err_stat[STAT_SB_FLAG] <= next_sb;
			if (mb_evt && !err_stat[STAT_MB_FLAG])
				err_stat[STAT_MB_ROW+:3] <= err_row;
			if (sb_evt && !err_stat[STAT_SB_FLAG])
				err_stat[STAT_SB_ROW+:3] <= err_row;
		end
	end

	// System error: one clock pulse, or level until flags clear
	always_ff @(posedge aclk) begin
		if (!aresetn)
			system_error_n <= 1'b1;
		else if (ecc_cfg[ECC_SERR_LVL])
			system_error_n <= !(next_mb || next_sb);
		else
			system_error_n <= !(mb_evt || sb_evt);
	end

	// Idle clock count before the host clock may stop
	assign idle_lim = 4'((pwb_ctl[PWB_IDLE_LSB+:2] + 3'h1) * IDLE_STEP);
	always_ff @(posedge aclk) begin
		if (!aresetn)
			idle_cnt <= 4'h0;
		else if (!(gate_clk_en && cpu_idle))
			idle_cnt <= 4'h0;
		else if (idle_cnt != idle_lim)
			idle_cnt <= idle_cnt + 4'h1;
	end
	assign host_clk_run = !gate_clk_en || (idle_cnt != idle_lim);

	// Overlap permissions are active low in the register
	assign ovl_pci_wr_ok = !pwb_ctl[PWB_NO_OVL_WR];
	assign ovl_pci_rd_ok = !pwb_ctl[PWB_NO_OVL_RD];

	// Flush timer; reserved codes fall back to the longest wait
	always_comb begin
		case (pwb_ctl[PWB_TMR_LSB+:3])
			3'h0:    flush_lim = FLUSH_4;
			3'h1:    flush_lim = FLUSH_8;
			3'h2:    flush_lim = FLUSH_12;
			3'h6:    flush_lim = FLUSH_16;
			default: flush_lim = FLUSH_32;
		endcase
	end

	// Each new write restarts the idle count of the line
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flush_cnt <= 6'h0;
			pwb_flush <= 1'b0;
		end else begin
			if (!pwb_pending || pwb_write)
				flush_cnt <= 6'h0;
			else if (flush_cnt != flush_lim)
				flush_cnt <= flush_cnt + 6'h1;
			pwb_flush <= pwb_pending && (pwb_ctl[PWB_IMMED]
				|| (!pwb_write && flush_cnt == flush_lim));
		end
	end

	// Pin synchronisers for the CPU status strobes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			smm_act_s <= 2'h3;
			cd_s      <= 2'h3;
		end else begin
			smm_act_s <= {smm_act_s[0], smm_active_n};
			cd_s      <= {cd_s[0], code_data_indicator_n};
		end
	end

	// Address decode; SMRAM overrides the plain windows
	assign seg    = mem_addr[31:16];
	assign smm_ok = !smm_act_s[1] || smm_cfg[SMM_ANY];
	always_comb begin
		next_local = (mem_addr < dram_top);
		next_addr  = mem_addr;
		if (mem_addr[31:17] == WIN_80K)
			next_local = !hole[HOLE_80K];
		if (seg == SEG_A || seg == SEG_B)
			next_local = hole[HOLE_AB];
		if (mem_addr[31:18] == WIN_SHADOW)
			next_local = mem_read && shadow[mem_addr[17:14]];
		if (mem_addr[31:20] == WIN_14M)
			next_local = hole[HOLE_14M] && (dram_top > TOP_15M);
		if (mem_addr[31:20] == WIN_15M)
			next_local = hole[HOLE_15M] && (dram_top > TOP_16M);
		if (smm_cfg[SMM_MAP]) begin
			case (smm_cfg[SMM_REG_LSB+:2])
				SMM_D_TO_B: begin
					if (seg == SEG_D) begin
						next_local = smm_ok;
						next_addr  = {SEG_B, mem_addr[15:0]};
					end
				end
				SMM_AB_SELF: begin
					if (seg == SEG_A || seg == SEG_B)
						next_local = smm_ok && !(smm_cfg[SMM_SPLIT]
							&& cd_s[1]);
				end
				SMM_3_TO_B: begin
					if (seg == SEG_3) begin
						next_local = 1'b1;
						if (smm_ok)
							next_addr = {SEG_B, mem_addr[15:0]};
					end
				end
				default: ;
			endcase
		end
	end

	// Decode result one clock after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dram_local <= 1'b0;
			dram_addr  <= 32'h0;
		end else begin
			dram_local <= next_local;
			dram_addr  <= next_addr;
		end
	end

	// Checks
	AST_AGP_SLICE: assert property (@(posedge aclk) disable iff (!aresetn)
		(agp_gnt && cmd_done && cmd_cnt == slice[7:4]) |=> !agp_gnt)
		else $error("AGP grant outlived its slice");
	AST_PCI_SLICE: assert property (@(posedge aclk) disable iff (!aresetn)
		(pci_gnt && cmd_done && cmd_cnt == slice[3:0]) |=> !pci_gnt)
		else $error("PCI grant outlived its slice");
	AST_GNT_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		(agp_gnt && agp_req && !slice_end) |=> agp_gnt)
		else $error("AGP grant dropped early");
	AST_SERR_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
		(!ecc_cfg[6] && !mb_evt && !sb_evt) |=> system_error_n)
		else $error("Pulse mode error held too long");
	AST_SERR_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
		($past(ecc_cfg[6]) && ecc_cfg[6])
		|-> (system_error_n == !(err_stat[4] || err_stat[0])))
		else $error("Level mode error out of step with flags");
	AST_SB_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
		(!(ecc_cfg[4] && ecc_cfg[0]) && !err_stat[0]) |=> !err_stat[0])
		else $error("Single-bit flag set while unchecked");
	AST_MB_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		mb_evt |=> err_stat[4])
		else $error("Multi-bit flag missed an error");
	AST_ROW_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
		(err_stat[4] && !mb_clr) |=> $stable(err_stat[7:5]))
		else $error("First-error row overwritten");
	AST_PAGE_AB: assert property (@(posedge aclk) disable iff (!aresetn)
		((seg == SEG_A) && !smm_cfg[0]) |=> (dram_local == $past(hole[3])))
		else $error("Page A-B decode wrong");
	AST_FORCE_80K: assert property (@(posedge aclk) disable iff (!aresetn)
		(mem_addr[31:17] == WIN_80K) |=> (dram_local == !$past(hole[2])))
		else $error("80000h window decode wrong");
endmodule // ddc_regs
`default_nettype wire

// ==== test/ddc_req_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ddc_req_model (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Grants from the sequencer
	input  wire logic       agp_gnt,
	input  wire logic       pci_gnt,
	// Bench control
	input  wire logic       slow,
	input  wire logic       load,
	input  wire logic [4:0] agp_want,
	input  wire logic [4:0] pci_want,
	// Requests and completions
	output logic            agp_req,
	output logic            pci_req,
	output logic            cmd_done
);
	logic [4:0] agp_left;
	logic [4:0] pci_left;
	logic       phase;

	// Masters keep asking while work is left, even across a lost grant
	assign agp_req  = agp_left != 5'h00;
	assign pci_req  = pci_left != 5'h00;
	// Slow mode finishes a command only every other cycle
	assign cmd_done = ((agp_gnt & agp_req) | (pci_gnt & pci_req)) &
		(~slow | phase);

	// Work left per master, one command retired per completion
	always_ff @(posedge aclk) begin
		if (!aresetn || load) begin
			agp_left <= aresetn ? agp_want : 5'h00;
			pci_left <= aresetn ? pci_want : 5'h00;
		end else begin
			agp_left <= agp_left - 5'((cmd_done & agp_gnt) ? 1 : 0);
			pci_left <= pci_left - 5'((cmd_done & pci_gnt) ? 1 : 0);
		end
	end

	// Pacing toggle for slow mode
	always_ff @(posedge aclk) begin
		phase <= aresetn ? ~phase : 1'b0;
	end
endmodule // ddc_req_model
`default_nettype wire

// ==== test/tb_ddc_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_ddc_regs;
	import ddc_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [11:0] ax_addr = 12'h000;
	logic [7:0]  wd = 8'h00;
	logic        awv = 1'b0, arv = 1'b0, axi_rdy = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, dram_addr, mem_addr = 32'h0;
	logic [31:0] dram_top = 32'h0110_0000;
	logic        agp_req, pci_req, cmd_done, agp_gnt, pci_gnt;
	logic        err_parity = 1'b0, err_multi = 1'b0, err_single = 1'b0;
	logic [2:0]  err_row = 3'h0;
	logic        ecc_mode, mb_check_en, sb_check_en, system_error_n;
	logic        gate_clk_en = 1'b0, cpu_idle = 1'b0, host_clk_run;
	logic        pwb_pending = 1'b0, pwb_write = 1'b0, pwb_flush;
	logic        ovl_pci_wr_ok, ovl_pci_rd_ok, dram_local;
	logic        mem_read = 1'b0, smm_active_n = 1'b1;
	logic        code_data_indicator_n = 1'b1;
	logic        slow = 1'b0, load = 1'b0;
	logic [4:0]  agp_want = 5'h00, pci_want = 5'h00;
	logic [7:0]  runs [$];
	logic [6:0]  run_cnt = 7'h00;
	logic        run_agp = 1'b0, in_run = 1'b0;
	int          num_errors = 0, cmp_count = 0;

	ddc_regs ddc_regs_i (
		.aclk, .aresetn,
		.s_axi_awaddr(ax_addr), .s_axi_awvalid(awv), .s_axi_awready,
		.s_axi_wdata({24'h000000, wd}), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(awv), .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready(axi_rdy), .s_axi_araddr(ax_addr),
		.s_axi_arvalid(arv), .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready(axi_rdy),
		.agp_req, .pci_req, .cmd_done, .agp_gnt, .pci_gnt,
		.err_parity, .err_multi, .err_single, .err_row, .ecc_mode,
		.mb_check_en, .sb_check_en, .system_error_n,
		.gate_clk_en, .cpu_idle, .host_clk_run,
		.pwb_pending, .pwb_write, .pwb_flush,
		.ovl_pci_wr_ok, .ovl_pci_rd_ok,
		.mem_addr, .mem_read, .dram_top, .smm_active_n,
		.code_data_indicator_n, .dram_local, .dram_addr
	);

	ddc_req_model ddc_req_model_i (
		.aclk, .aresetn, .agp_gnt, .pci_gnt, .slow, .load,
		.agp_want, .pci_want, .agp_req, .pci_req, .cmd_done
	);

	// Free-running 100 MHz clock
	initial begin
		forever #5 aclk = ~aclk;
	end

	// Record each grant as master and command count once it ends
	always @(negedge aclk) begin
		if (agp_gnt | pci_gnt) begin
			run_cnt = run_cnt + 7'(cmd_done);
			run_agp = agp_gnt;
			in_run = 1'b1;
		end else if (in_run) begin
			runs.push_back({run_agp, run_cnt});
			run_cnt = 7'h00;
			in_run = 1'b0;
		end
	end

	task automatic tally_and_finish();
		if (num_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	// Address and data offered together; response held until taken
	task automatic wr(input logic [7:0] idx, input logic [7:0] d,
		input logic [1:0] er = RESP_OKAY);
		@(posedge aclk);
		ax_addr <= {2'h0, idx, 2'h0};
		wd <= d;
		awv <= 1'b1;
		axi_rdy <= 1'b1;
		do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
		awv <= 1'b0;
		do @(posedge aclk); while (!s_axi_bvalid);
		cmp_val({30'h0, s_axi_bresp}, {30'h0, er});
		axi_rdy <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] e,
		input logic [1:0] er = RESP_OKAY);
		@(posedge aclk);
		ax_addr <= {2'h0, idx, 2'h0};
		arv <= 1'b1;
		axi_rdy <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		arv <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		cmp_val(s_axi_rdata, {24'h0, e});
		cmp_val({30'h0, s_axi_rresp}, {30'h0, er});
		axi_rdy <= 1'b0;
	endtask

	// Reset values, writable bits and the unmapped hole
	task automatic t_regs();
		logic [7:0] m [9] = '{8'hff, 8'h71, 8'h00, 8'h00, 8'hff, 8'h3c,
			8'h1f, 8'hff, 8'hff};
		cmp_val({27'h0, ecc_mode, system_error_n, ovl_pci_wr_ok,
			ovl_pci_rd_ok, host_clk_run}, 32'h0f);
		for (int i = 0; i < 9; i++) begin
			rd(IDX_SLICE + 8'(i), REG_RESET);
			wr(IDX_SLICE + 8'(i), 8'hff);
			rd(IDX_SLICE + 8'(i), m[i]);
			wr(IDX_SLICE + 8'(i), 8'h00);
		end
		wr(8'h60, 8'h55, RESP_SLVERR);
		rd(8'h60, 8'h00, RESP_SLVERR);
	endtask

	// One-cycle error pulse, returns where its effect has landed
	task automatic ev(input logic [2:0] k, input logic [2:0] r);
		@(posedge aclk);
		{err_parity, err_multi, err_single} <= k;
		err_row <= r;
		@(posedge aclk);
		{err_parity, err_multi, err_single} <= 3'h0;
		@(negedge aclk);
	endtask

	task automatic t_err();
		wr(IDX_ECC_CFG, 8'h31);
		cmp_val({31'h0, ecc_mode}, 32'h1);
		ev(3'h2, 3'h5);
		cmp_val({31'h0, system_error_n}, 32'h0);
		@(negedge aclk);
		cmp_val({31'h0, system_error_n}, 32'h1);
		ev(3'h2, 3'h2);
		rd(IDX_ERR_STAT, 8'hb0);
		wr(IDX_ERR_STAT, 8'h00);
		rd(IDX_ERR_STAT, 8'hb0);
		ev(3'h1, 3'h3);
		rd(IDX_ERR_STAT, 8'hb7);
		wr(IDX_ERR_STAT, 8'h10);
		ev(3'h2, 3'h1);
		rd(IDX_ERR_STAT, 8'h37);
		wr(IDX_ERR_STAT, 8'h11);
		wr(IDX_ECC_CFG, 8'h71);
		ev(3'h1, 3'h0);
		ev(3'h2, 3'h0);
		wr(IDX_ERR_STAT, 8'h01);
		cmp_val({31'h0, system_error_n}, 32'h0);
		wr(IDX_ERR_STAT, 8'h10);
		cmp_val({31'h0, system_error_n}, 32'h1);
		wr(IDX_ECC_CFG, 8'h01);
		cmp_val({30'h0, mb_check_en, sb_check_en}, 32'h0);
		ev(3'h3, 3'h4);
		cmp_val({31'h0, system_error_n}, 32'h1);
		rd(IDX_ERR_STAT, 8'h00);
		wr(IDX_ECC_CFG, 8'h30);
		ev(3'h5, 3'h4);
		cmp_val({29'h0, ecc_mode, sb_check_en, system_error_n}, 32'h0);
		rd(IDX_ERR_STAT, 8'h90);
		wr(IDX_ERR_STAT, 8'h10);
		wr(IDX_ECC_CFG, 8'h00);
	endtask

	// Each timer code, one reserved code, then immediate flush
	task automatic t_flush();
		int n;
		logic [7:0] c;
		logic [2:0] code [6] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7, 3'h3};
		int lim [6] = '{4, 8, 12, 16, 32, 32};
		for (int i = 0; i < 7; i++) begin
			c = (i == 6) ? 8'h31 : {2'h0, 2'(i), code[i], 1'b0};
			wr(IDX_PWB, c);
			cmp_val({30'h0, ovl_pci_wr_ok, ovl_pci_rd_ok}, {30'h0, ~c[5:4]});
			@(posedge aclk);
			pwb_pending <= 1'b1;
			n = 0;
			do begin
				@(negedge aclk);
				n++;
			end while (!pwb_flush && n < 40);
			cmp_val(n, (i == 6) ? 2 : lim[i] + 2);
			@(posedge aclk);
			pwb_pending <= 1'b0;
		end
		// A write in mid-count restarts the idle timer of the line
		wr(IDX_PWB, 8'h00);
		@(posedge aclk);
		pwb_pending <= 1'b1;
		repeat (3) @(posedge aclk);
		pwb_write <= 1'b1;
		@(posedge aclk);
		pwb_write <= 1'b0;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (!pwb_flush && n < 40);
		cmp_val(n, 6);
		@(posedge aclk);
		pwb_pending <= 1'b0;
	endtask

	// Gated host clock lingers for 2, 4, 6 or 8 idle clocks
	task automatic t_idle();
		int n;
		for (int s = 0; s < 4; s++) begin
			wr(IDX_PWB, 8'(s << 6));
			@(posedge aclk);
			gate_clk_en <= 1'b1;
			cpu_idle <= 1'b1;
			n = 0;
			do begin
				@(negedge aclk);
				n++;
			end while (host_clk_run && n < 20);
			cmp_val(n, 2 * s + 3);
			@(posedge aclk);
			cpu_idle <= 1'b0;
			gate_clk_en <= 1'b0;
		end
	endtask

	// Grant runs checked against the slice, oldest run first
	task automatic t_arb(input logic s, input logic [7:0] sl,
		input logic [4:0] aw, input logic [4:0] pw, input int n,
		input logic [47:0] ex);
		wr(IDX_SLICE, sl);
		runs.delete();
		@(posedge aclk);
		slow <= s;
		agp_want <= aw;
		pci_want <= pw;
		load <= 1'b1;
		@(posedge aclk);
		load <= 1'b0;
		repeat (90) @(posedge aclk);
		cmp_val(runs.size(), n);
		for (int i = 0; i < n; i++)
			cmp_val({24'h0, runs[i]}, {24'h0, ex[8 * (n - 1 - i) +: 8]});
	endtask

	// Decode one address; pins are read, smm active and code/data
	task automatic dec(input logic [7:0] hole, input logic [7:0] smm,
		input logic [15:0] sh, input logic [23:0] a,
		input logic [2:0] pins, input logic loc, input logic [23:0] da);
		wr(IDX_HOLE, hole);
		wr(IDX_SMM, smm);
		wr(IDX_SHAD_LO, sh[7:0]);
		wr(IDX_SHAD_HI, sh[15:8]);
		@(posedge aclk);
		mem_addr <= {8'h00, a};
		{mem_read, smm_active_n, code_data_indicator_n} <= pins;
		repeat (4) @(negedge aclk);
		cmp_val({31'h0, dram_local}, {31'h0, loc});
		if (loc)
			cmp_val(dram_addr, {8'h00, da});
	endtask

	task automatic t_dec();
		dec(8'h00, 8'h00, 16'h0, 24'h0a0000, 3'h7, 0, 24'h0);
		dec(8'h08, 8'h00, 16'h0, 24'h0a0000, 3'h7, 1, 24'h0a0000);
		dec(8'h00, 8'h00, 16'h0, 24'h080000, 3'h7, 1, 24'h080000);
		dec(8'h04, 8'h00, 16'h0, 24'h080000, 3'h7, 0, 24'h0);
		dec(8'h20, 8'h00, 16'h0, 24'he00000, 3'h7, 1, 24'he00000);
		dec(8'h00, 8'h00, 16'h0, 24'he00000, 3'h7, 0, 24'h0);
		dec(8'h10, 8'h00, 16'h0, 24'hf00000, 3'h7, 1, 24'hf00000);
		dec(8'h00, 8'h00, 16'h1, 24'h0c0000, 3'h7, 1, 24'h0c0000);
		dec(8'h00, 8'h00, 16'h1, 24'h0c4000, 3'h7, 0, 24'h0);
		dec(8'h00, 8'h00, 16'h8000, 24'h0fc000, 3'h7, 1, 24'h0fc000);
		dec(8'h00, 8'h00, 16'h8000, 24'h0fc000, 3'h3, 0, 24'h0);
		dec(8'h00, 8'h01, 16'h10, 24'h0d0000, 3'h5, 1, 24'h0b0000);
		dec(8'h00, 8'h01, 16'h10, 24'h0d0000, 3'h7, 0, 24'h0);
		dec(8'h00, 8'h03, 16'h10, 24'h0d0000, 3'h7, 1, 24'h0b0000);
		dec(8'h00, 8'h09, 16'h0, 24'h030000, 3'h7, 1, 24'h030000);
		dec(8'h00, 8'h09, 16'h0, 24'h030000, 3'h5, 1, 24'h0b0000);
		dec(8'h00, 8'h15, 16'h0, 24'h0a0000, 3'h4, 1, 24'h0a0000);
		dec(8'h00, 8'h15, 16'h0, 24'h0a0000, 3'h5, 0, 24'h0);
		dec(8'h00, 8'h0d, 16'h10, 24'h0d0000, 3'h5, 1, 24'h0d0000);
		// Installed memory of exactly 16M: only the 14M window qualifies
		@(posedge aclk);
		dram_top <= 32'h0100_0000;
		dec(8'h20, 8'h00, 16'h0, 24'he00000, 3'h7, 1, 24'he00000);
		dec(8'h10, 8'h00, 16'h0, 24'hf00000, 3'h7, 0, 24'h0);
		wr(IDX_SMM, 8'h00);
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_err();
		t_flush();
		t_idle();
		t_arb(1'b0, 8'h10, 5'h05, 5'h03, 6, 48'h820182018101);
		t_arb(1'b1, 8'h10, 5'h05, 5'h03, 6, 48'h820182018101);
		t_arb(1'b0, 8'hf0, 5'h11, 5'h00, 2, 48'h9081);
		t_dec();
		tally_and_finish();
	end

	// A hang is cut short well beyond the expected run length
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		tally_and_finish();
	end
endmodule // tb_ddc_regs
`default_nettype wire
